/* File: tb/pmip_link_partner.sv */
`timescale 1ns/100ps

module pmip_link_partner
(
    // clock
    input  wire logic        clk_i,
    // frame descriptor, flags are crc, fc, bcast, mcast, flood
    output logic             frm_end_o,
    output logic [13:0]      frm_len_o,
    output logic [4:0]       frm_flags_o,
    output logic [2:0]       frm_prio_o
);

    initial
    begin
        frm_end_o   = 1'b0;
        frm_len_o   = 14'h0000;
        frm_flags_o = 5'h00;
        frm_prio_o  = 3'h0;
    end

    ////////////////////////////////////////////////////////////////////////
    // one descriptor pulse, then fields go stale as inverted values
    task send(input logic [13:0] len, input logic [4:0] fl, input logic [2:0] pr);
        @(posedge clk_i);
        frm_end_o   <= 1'b1;
        frm_len_o   <= len;
        frm_flags_o <= fl;
        frm_prio_o  <= pr;
        @(posedge clk_i);
        frm_end_o   <= 1'b0;
        frm_len_o   <= ~len;
        frm_flags_o <= ~fl;
        frm_prio_o  <= ~pr;
    endtask

endmodule // pmip_link_partner

/* File: tb/tb.sv */
`timescale 1ns/100ps
`include "pmip_defines.svh"

module tb;
    localparam int WIN = 500;
    localparam logic [15:0] A_FEAT = 16'(`PMIP_IDX_FEATURE * 4);
    localparam logic [15:0] A_FRM  = 16'(`PMIP_IDX_FRAME * 4);
    localparam logic [15:0] A_FC   = 16'(`PMIP_IDX_FCCFG * 4);
    localparam logic [15:0] A_POL  = 16'(`PMIP_IDX_POLICE * 4);

    typedef struct packed
    {
        logic [7:0]  feat;
        logic [7:0]  fh;
        logic        filt;
        logic [13:0] len;
        logic [4:0]  fl;
        logic [2:0]  x;
    } pmip_frow_t;

    logic        clk, rst_n, psel, penable, pwrite, dup, cong, filt, er;
    logic        pready, pslverr, fwd, drop, mir, bp, pause, f_end;
    logic [15:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [13:0] f_len;
    logic [4:0]  f_fl;
    logic [2:0]  f_pr;
    int          n_fail, checks, i, k;

    // verdict rows: {fwd, drop, mirror}
    pmip_frow_t  rows [11] = '{
        '{8'h00, 8'h00, 1'b0, 14'd64, 5'h00, 3'b100},
        '{8'h00, 8'h00, 1'b0, 14'd63, 5'h00, 3'b010},
        '{8'h00, 8'h00, 1'b0, 14'd1518, 5'h00, 3'b100},
        '{8'h00, 8'h00, 1'b0, 14'd1519, 5'h00, 3'b010},
        '{8'h01, 8'h00, 1'b0, 14'd9018, 5'h00, 3'b100},
        '{8'h01, 8'h00, 1'b0, 14'd9019, 5'h00, 3'b010},
        '{8'h00, 8'h01, 1'b0, 14'd63, 5'h00, 3'b101},
        '{8'h00, 8'h01, 1'b0, 14'd64, 5'h10, 3'b101},
        '{8'h00, 8'h01, 1'b1, 14'd64, 5'h08, 3'b010},
        '{8'h00, 8'h01, 1'b0, 14'd64, 5'h08, 3'b100},
        '{8'h00, 8'h00, 1'b0, 14'd64, 5'h10, 3'b010}};
    // flow rows: {dup, bp_en, pause_en, congested, exp_bp, exp_pause}
    logic [5:0]  fr [6] = '{6'b010110, 6'b000100, 6'b011000,
                            6'b110100, 6'b111101, 6'b100100};
    logic [15:0] ra [4] = '{A_FEAT, A_FRM, A_FC, A_POL};
    logic [7:0]  rm [4] = '{`PMIP_FEAT_WMASK, `PMIP_FRAME_WMASK,
                            `PMIP_FCCFG_WMASK, `PMIP_POLICE_WMASK};
    logic [7:0]  bpol [5] = '{8'h00, 8'h02, 8'h01, 8'h21, 8'h20};
    int          bn [5] = '{2, 2, 2, 1, 2};
    logic [13:0] bl [5] = '{14'd615, 14'd615, 14'd621, 14'd64, 14'd64};
    logic [2:0]  bx [5] = '{3'b100, 3'b010, 3'b010, 3'b100, 3'b010};
    logic [4:0]  kf [4] = '{5'h00, 5'h01, 5'h02, 5'h04};

    pmip_port_ctrl #(.WINDOW_CYCLES(WIN)) i_pmip_port_ctrl
    (
        .CLK_I(clk), .RESET_N_I(rst_n),
        .PSEL_I(psel), .PENABLE_I(penable), .PWRITE_I(pwrite),
        .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr),
        .FULL_DUPLEX_I(dup), .CONGESTED_I(cong), .FC_FRAME_FILTER_I(filt),
        .FRM_END_I(f_end), .FRM_LEN_I(f_len), .FRM_CRC_ERR_I(f_fl[4]),
        .FRM_FC_I(f_fl[3]), .FRM_BCAST_I(f_fl[2]), .FRM_MCAST_I(f_fl[1]),
        .FRM_FLOOD_I(f_fl[0]), .FRM_PRIO_I(f_pr),
        .FRM_FWD_O(fwd), .FRM_DROP_O(drop), .FRM_MIRROR_ONLY_O(mir),
        .BACKPRESSURE_O(bp), .PAUSE_REQ_O(pause)
    );

    pmip_link_partner i_pmip_link_partner
    (
        .clk_i(clk), .frm_end_o(f_end), .frm_len_o(f_len),
        .frm_flags_o(f_fl), .frm_prio_o(f_pr)
    );

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    function automatic logic [15:0] alim(input int p);
        return 16'((`PMIP_IDX_LIM0 + p) * 4);
    endfunction

    task stop_test;
        if (n_fail == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    task chk(input logic [31:0] g, input logic [31:0] e);
        checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error at %0t: got %h, expected %h", $time, g, e);
        end
    endtask

    task apb(input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= {24'h000000, d};
        @(posedge clk);
        penable <= 1'b1;
        do
        begin
            @(posedge clk);
        end
        while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    task wr(input logic [15:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask

    task rdc(input logic [15:0] a, input logic [7:0] e);
        apb(1'b0, a, 8'h00);
        chk(rd, {24'h000000, e});
    endtask

    task frm(input logic [13:0] len, input logic [4:0] fl, input logic [2:0] pr,
             input logic [2:0] x);
        i_pmip_link_partner.send(len, fl, pr);
        #1;
        chk({29'h0, fwd, drop, mir}, {29'h0, x});
    endtask

    // drive prio 0 over its limit, then wait for the window to clear it
    task sync_win;
        int n;
        wr(A_FC, 8'h02);
        wr(A_POL, 8'h70);
        n = 0;
        while (pause !== 1'b1 && n < 8)
        begin
            frm(14'd64, 5'h00, 3'd0, 3'b100);
            n++;
        end
        chk({31'h0, pause}, 32'h1);
        n = 0;
        while (pause !== 1'b0 && n < 2 * WIN)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        chk({31'h0, pause}, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        #300000;
        n_fail++;
        stop_test;
    end

    initial
    begin
        {rst_n, psel, penable, pwrite, dup, cong, filt} = 7'h00;
        paddr = 16'h0000;
        pwdata = 32'h00000000;
        n_fail = 0;
        checks = 0;
        repeat (5) @(posedge clk);
        rst_n <= 1'b1;
        repeat (3) @(posedge clk);
        for (i = 0; i < 4; i++)
        begin
            rdc(ra[i], 8'h00);
            wr(ra[i], 8'hff);
            rdc(ra[i], rm[i]);
            wr(ra[i], 8'h00);
        end
        rdc(alim(0), 8'h00);
        wr(16'h1010, 8'hff);
        chk({31'h0, er}, 32'h1);
        chk({31'h0, pready}, 32'h1);
        rdc(16'h1010, 8'h00);
        apb(1'b0, 16'h1001, 8'h00);
        chk({31'h0, er}, 32'h1);
        for (i = 0; i < 11; i++)
        begin
            wr(A_FEAT, rows[i].feat);
            wr(A_FRM, rows[i].fh);
            filt <= rows[i].filt;
            frm(rows[i].len, rows[i].fl, 3'd6, rows[i].x);
        end
        for (i = 0; i < 6; i++)
        begin
            @(posedge clk);
            dup  <= fr[i][5];
            cong <= fr[i][2];
            wr(A_FRM, {4'h0, fr[i][4], 3'h0});
            wr(A_FC, {7'h00, fr[i][3]});
            repeat (5) @(posedge clk);
            #1;
            chk({30'h0, bp, pause}, {30'h0, fr[i][1:0]});
        end
        @(posedge clk);
        cong <= 1'b0;
        wr(A_FRM, 8'h00);
        for (i = 0; i < 6; i++) wr(alim(i), 8'h01);
        rdc(alim(0), 8'h01);
        wr(A_FC, 8'h02);
        wr(A_POL, 8'h70);
        for (i = 0; i < 3; i++) frm(14'd64, 5'h00, 3'd0, 3'b100);
        chk({31'h0, pause}, 32'h0);
        wr(alim(7), 8'h00);
        sync_win;
        // byte and packet metering, one priority per case
        for (i = 0; i < 5; i++)
        begin
            wr(A_POL, bpol[i]);
            for (k = 0; k < bn[i]; k++) frm(bl[i], 5'h00, 3'(i + 1), 3'b100);
            frm(14'd64, 5'h00, 3'(i + 1), bx[i]);
        end
        sync_win;
        wr(A_FC, 8'h00);
        for (i = 0; i < 3; i++) frm(14'd64, 5'h00, 3'd0, 3'b100);
        chk({31'h0, pause}, 32'h0);
        rdc(A_FC, 8'h80);
        for (i = 0; i < 4; i++)
        begin
            wr(A_POL, 8'(8'h60 | (i << 2)));
            for (k = 0; k < 4; k++) frm(14'd64, kf[k], 3'd0, (k >= i) ? 3'b010 : 3'b100);
        end
        wr(A_POL, 8'h20);
        frm(14'd64, 5'h00, 3'd0, 3'b010);
        frm(14'd64, 5'h00, 3'd6, 3'b100);
        sync_win;
        wr(A_POL, 8'h00);
        wr(A_FEAT, 8'h02);
        for (i = 0; i <= 100; i++) frm(14'd64, 5'h04, 3'd6, (i < 100) ? 3'b100 : 3'b010);
        wr(A_FEAT, 8'h00);
        frm(14'd64, 5'h04, 3'd6, 3'b100);
        // mid-run reset clears the feature and flow control bits and both flow control outputs
        wr(A_FEAT, 8'h0b);
        wr(A_FC, 8'h03);
        cong <= 1'b1;
        repeat (3) @(posedge clk);
        #1;
        chk({31'h0, pause}, 32'h1);
        @(posedge clk);
        rst_n <= 1'b0;
        @(posedge clk);
        rst_n <= 1'b1;
        #1;
        chk({30'h0, bp, pause}, 32'h0);
        repeat (3) @(posedge clk);
        rdc(A_FEAT, 8'h00);
        rdc(A_FC, 8'h00);
        stop_test;
    end

endmodule // tb

/* File: verilog/pmip_defines.svh */
`ifndef PMIP_DEFINES_SVH
`define PMIP_DEFINES_SVH

// register indices, byte address is four times the index
`define PMIP_IDX_FEATURE  12'h400
`define PMIP_IDX_FRAME    12'h401
`define PMIP_IDX_FCCFG    12'h402
`define PMIP_IDX_POLICE   12'h403
`define PMIP_IDX_LIM0     12'h410
`define PMIP_IDX_LIM7     12'h417

// reset value and writable masks
`define PMIP_RESET_VAL    8'h00
`define PMIP_FEAT_WMASK   8'h0b
`define PMIP_FRAME_WMASK  8'hbf
`define PMIP_POLICE_WMASK 8'h7f
`define PMIP_FCCFG_WMASK  8'h03
`define PMIP_LIM_WMASK    8'h7f

// field positions
`define PMIP_FEAT_JUMBO   0
`define PMIP_FEAT_STORM   1
`define PMIP_FRAME_PASS   0
`define PMIP_FRAME_BP     3
`define PMIP_POL_PRE      0
`define PMIP_POL_IFG      1
`define PMIP_POL_CLS_LO   2
`define PMIP_POL_CLS_HI   3
`define PMIP_POL_RLFC     4
`define PMIP_POL_PKT      5
`define PMIP_POL_PORT     6
`define PMIP_FC_PAUSE     0
`define PMIP_FC_PERMIT    1
`define PMIP_FC_OVER      7

// frame lengths in bytes
`define PMIP_MIN_FRAME    14'd64
`define PMIP_OVERHEAD     14'd18
`define PMIP_STD_PAYLOAD  14'd1500
`define PMIP_JUMBO_PAYLD  14'd9000
`define PMIP_IFG_BYTES    14'd12
`define PMIP_PRE_BYTES    14'd8

// metering
`define PMIP_PKT_AMOUNT   24'd1
`define PMIP_UNIT_BYTES   24'd1250
`define PMIP_UNIT_PKTS    24'd2
`define PMIP_STORM_LIMIT  24'd100
`define PMIP_CLK_MHZ      100
`define PMIP_WINDOW_US    1000
`define PMIP_WIN_W        24

`endif

/* File: verilog/pmip_pkg.sv */
package pmip_pkg;
    typedef logic [7:0]  pmip_reg_t;
    typedef logic [23:0] pmip_amount_t;
    typedef enum logic [1:0]
    {
        PMIP_CLS_ALL   = 2'h0,
        PMIP_CLS_FLOOD = 2'h1,
        PMIP_CLS_MCAST = 2'h2,
        PMIP_CLS_BCAST = 2'h3
    } pmip_class_t;
endpackage

/* File: verilog/pmip_port_ctrl.sv */
// Summary of operation
// - storm protection bit drops excess broadcasts
// - jumbo bit raises payload limit to 9000
// - back pressure only in half duplex
// - full duplex uses separately enabled pause
// - bad frames dropped unless pass-all mirrors them
// - pass-all leaves flow control filtering alone
// - granularity bit: port or priority limiting
// - packet-count bit selects packets or bytes
// - rate overrun asserts flow control when enabled
// - overrun flow control needs port permission
// - class field selects counted frames
// - IFG bit adds 12 bytes per frame
// - preamble bit adds 8 bytes per frame
// - preamble ignored in packet-count mode
// - control bits reset to zero
// - priority limits apply on priority 7 write
// - port permission bit gates only overrun flow control
`timescale 1ns/100ps
`include "pmip_defines.svh"

module pmip_port_ctrl
#(
    parameter int WINDOW_CYCLES = `PMIP_WINDOW_US * `PMIP_CLK_MHZ
)
(
    // clock and reset
    input  wire logic        CLK_I,
    input  wire logic        RESET_N_I,
    // apb slave
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [15:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    // link and switch status
    input  wire logic        FULL_DUPLEX_I,
    input  wire logic        CONGESTED_I,
    input  wire logic        FC_FRAME_FILTER_I,
    // received frame descriptor
    input  wire logic        FRM_END_I,
    input  wire logic [13:0] FRM_LEN_I,
    input  wire logic        FRM_CRC_ERR_I,
    input  wire logic        FRM_FC_I,
    input  wire logic        FRM_BCAST_I,
    input  wire logic        FRM_MCAST_I,
    input  wire logic        FRM_FLOOD_I,
    input  wire logic [2:0]  FRM_PRIO_I,
    // frame verdict and flow control
    output logic             FRM_FWD_O,
    output logic             FRM_DROP_O,
    output logic             FRM_MIRROR_ONLY_O,
    output logic             BACKPRESSURE_O,
    output logic             PAUSE_REQ_O
);

    ////////////////////////////////////////////////////////////////////////////////
    // reset and pin synchronisers

    logic [1:0] rst_sync_q;
    logic       rst_n, dup_meta_q, dup_q;

    assign rst_n = rst_sync_q[1];

    always_ff @(posedge CLK_I or negedge RESET_N_I)
    begin
        if (!RESET_N_I)
            rst_sync_q <= 2'h0;
        else
            rst_sync_q <= {rst_sync_q[0], 1'b1};
    end

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            dup_meta_q <= 1'b0;
            dup_q      <= 1'b0;
        end
        else
        begin
            dup_meta_q <= FULL_DUPLEX_I;
            dup_q      <= dup_meta_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode

    pmip_pkg::pmip_reg_t feat_q;
    pmip_pkg::pmip_reg_t frame_q;
    pmip_pkg::pmip_reg_t fccfg_q;
    pmip_pkg::pmip_reg_t police_q;
    pmip_pkg::pmip_reg_t lim_stage_q [8];
    pmip_pkg::pmip_reg_t lim_act_q   [8];
    logic [31:0]         prdata_q;
    logic [11:0]         idx;
    logic                aligned, hit_feat, hit_frame, hit_fccfg, hit_police, hit_lim;
    logic                hit_any, wr_en, rd_setup, wr_lim7, over_any;
    logic [2:0]          lim_sel;
    pmip_pkg::pmip_reg_t wdata, rdata;

    assign idx        = PADDR_I[13:2];
    assign aligned    = (PADDR_I[1:0] == 2'h0) && (PADDR_I[15:14] == 2'h0);
    assign hit_feat   = aligned && (idx == `PMIP_IDX_FEATURE);
    assign hit_frame  = aligned && (idx == `PMIP_IDX_FRAME);
    assign hit_fccfg  = aligned && (idx == `PMIP_IDX_FCCFG);
    assign hit_police = aligned && (idx == `PMIP_IDX_POLICE);
    assign hit_lim    = aligned && (idx >= `PMIP_IDX_LIM0) && (idx <= `PMIP_IDX_LIM7);
    assign hit_any    = hit_feat || hit_frame || hit_fccfg || hit_police || hit_lim;
    assign lim_sel    = idx[2:0];
    assign wr_en      = PSEL_I && PENABLE_I && PWRITE_I && hit_any;
    assign rd_setup   = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign wr_lim7    = wr_en && hit_lim && (lim_sel == 3'h7);
    assign wdata      = PWDATA_I[7:0];
    assign PREADY_O   = 1'b1;
    assign PSLVERR_O  = PSEL_I && PENABLE_I && !hit_any;
    assign PRDATA_O   = prdata_q;

    assign rdata = hit_feat   ? feat_q
                 : hit_frame  ? frame_q
                 : hit_fccfg  ? (fccfg_q | (8'(over_any) << `PMIP_FC_OVER))
                 : hit_police ? police_q
                 : hit_lim    ? lim_stage_q[lim_sel]
                 : 8'h00;

    ////////////////////////////////////////////////////////////////////////////////
    // control registers

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            feat_q   <= `PMIP_RESET_VAL;
            frame_q  <= `PMIP_RESET_VAL;
            fccfg_q  <= `PMIP_RESET_VAL;
            police_q <= `PMIP_RESET_VAL;
            prdata_q <= 32'h0;
        end
        else
        begin
            if (wr_en && hit_feat)
                feat_q <= wdata & `PMIP_FEAT_WMASK;
            if (wr_en && hit_frame)
                frame_q <= wdata & `PMIP_FRAME_WMASK;
            if (wr_en && hit_fccfg)
                fccfg_q <= wdata & `PMIP_FCCFG_WMASK;
            if (wr_en && hit_police)
                police_q <= wdata & `PMIP_POLICE_WMASK;
            if (rd_setup)
                prdata_q <= {24'h0, rdata};
        end
    end

    // staged limits, all applied together on the priority 7 write
    genvar g;
    generate
        for (g = 0; g < 8; g++)
        begin : g_lim
            always_ff @(posedge CLK_I or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    lim_stage_q[g] <= `PMIP_RESET_VAL;
                    lim_act_q[g]   <= `PMIP_RESET_VAL;
                end
                else
                begin
                    if (wr_en && hit_lim && (lim_sel == 3'(g)))
                        lim_stage_q[g] <= wdata & `PMIP_LIM_WMASK;
                    if (wr_lim7)
                        lim_act_q[g] <= (g == 7) ? (wdata & `PMIP_LIM_WMASK)
                                                 : lim_stage_q[g];
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // field views

    logic       jumbo, storm_en, pass_all, bp_en, pre_en, ifg_en;
    logic       rlfc_en, pkt_mode, port_based, pause_en, fc_permit;
    logic [1:0] cls;

    assign jumbo      = feat_q[`PMIP_FEAT_JUMBO];
    assign storm_en   = feat_q[`PMIP_FEAT_STORM];
    assign pass_all   = frame_q[`PMIP_FRAME_PASS];
    assign bp_en      = frame_q[`PMIP_FRAME_BP];
    assign pre_en     = police_q[`PMIP_POL_PRE];
    assign ifg_en     = police_q[`PMIP_POL_IFG];
    assign cls        = police_q[`PMIP_POL_CLS_HI:`PMIP_POL_CLS_LO];
    assign rlfc_en    = police_q[`PMIP_POL_RLFC];
    assign pkt_mode   = police_q[`PMIP_POL_PKT];
    assign port_based = police_q[`PMIP_POL_PORT];
    assign pause_en   = fccfg_q[`PMIP_FC_PAUSE];
    assign fc_permit  = fccfg_q[`PMIP_FC_PERMIT];

    ////////////////////////////////////////////////////////////////////////////////
    // frame checks and metering

    logic [31:0]            win_cnt_q;
    logic [13:0]            max_len, byte_cnt;
    logic [2:0]             meter_sel;
    logic [7:0]             over_vec;
    pmip_pkg::pmip_amount_t amount, unit;
    logic                   win_tick, too_long, too_short, bad, fc_drop, class_hit;
    logic                   count_hit, rate_over, storm_over, storm_drop, rate_drop;
    logic                   fc_rate, drop_now;

    assign win_tick  = (win_cnt_q == 32'(WINDOW_CYCLES - 1));
    assign max_len   = (jumbo ? `PMIP_JUMBO_PAYLD : `PMIP_STD_PAYLOAD)
                     + `PMIP_OVERHEAD;
    assign too_long  = FRM_LEN_I > max_len;
    assign too_short = FRM_LEN_I < `PMIP_MIN_FRAME;
    assign bad       = FRM_CRC_ERR_I || too_long || too_short;
    assign fc_drop   = FRM_FC_I && FC_FRAME_FILTER_I;

    assign class_hit = (cls == pmip_pkg::PMIP_CLS_ALL)
                    || (cls == pmip_pkg::PMIP_CLS_FLOOD
                        && (FRM_BCAST_I || FRM_MCAST_I || FRM_FLOOD_I))
                    || (cls == pmip_pkg::PMIP_CLS_MCAST && (FRM_BCAST_I || FRM_MCAST_I))
                    || (cls == pmip_pkg::PMIP_CLS_BCAST && FRM_BCAST_I);

    assign meter_sel = port_based ? 3'h0 : FRM_PRIO_I;
    assign byte_cnt  = FRM_LEN_I
                     + (ifg_en ? `PMIP_IFG_BYTES : 14'h0)
                     + (pre_en ? `PMIP_PRE_BYTES : 14'h0);
    assign amount    = pkt_mode ? `PMIP_PKT_AMOUNT : {10'h0, byte_cnt};
    assign unit      = pkt_mode ? `PMIP_UNIT_PKTS : `PMIP_UNIT_BYTES;
    assign count_hit = FRM_END_I && class_hit && !fc_drop && !(bad && !pass_all);
    assign rate_over = over_vec[meter_sel];
    assign over_any  = |over_vec;

    generate
        for (g = 0; g < 8; g++)
        begin : g_meter
            pmip_rate_meter u_meter
            (
                .clk_i      (CLK_I),
                .rst_n_i    (rst_n),
                .win_tick_i (win_tick),
                .hit_i      (count_hit && (meter_sel == 3'(g))),
                .amount_i   (amount),
                .limit_i    (24'(lim_act_q[g][6:0]) * unit),
                .over_o     (over_vec[g])
            );
        end
    endgenerate

    pmip_rate_meter u_storm
    (
        .clk_i      (CLK_I),
        .rst_n_i    (rst_n),
        .win_tick_i (win_tick),
        .hit_i      (FRM_END_I && FRM_BCAST_I && storm_en),
        .amount_i   (`PMIP_PKT_AMOUNT),
        .limit_i    (`PMIP_STORM_LIMIT),
        .over_o     (storm_over)
    );

    assign storm_drop = storm_en && FRM_BCAST_I && storm_over;
    assign rate_drop  = class_hit && rate_over && !rlfc_en;
    assign fc_rate    = rlfc_en && fc_permit && over_any;
    assign drop_now   = fc_drop || (bad && !pass_all) || storm_drop || rate_drop;

    ////////////////////////////////////////////////////////////////////////////////
    // verdict and flow control outputs

    always_ff @(posedge CLK_I or negedge rst_n)
    begin
        if (!rst_n)
        begin
            win_cnt_q         <= 32'h0;
            FRM_FWD_O         <= 1'b0;
            FRM_DROP_O        <= 1'b0;
            FRM_MIRROR_ONLY_O <= 1'b0;
            BACKPRESSURE_O    <= 1'b0;
            PAUSE_REQ_O       <= 1'b0;
        end
        else
        begin
            win_cnt_q         <= win_tick ? 32'h0 : win_cnt_q + 32'h1;
            FRM_FWD_O         <= FRM_END_I && !drop_now;
            FRM_DROP_O        <= FRM_END_I && drop_now;
            FRM_MIRROR_ONLY_O <= FRM_END_I && !drop_now && bad && pass_all;
            BACKPRESSURE_O    <= !dup_q && bp_en && (CONGESTED_I || fc_rate);
            PAUSE_REQ_O       <= dup_q && ((pause_en && CONGESTED_I) || fc_rate);
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // checks

    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!rst_n);

    a_storm_gate: assert property
        ((FRM_END_I && storm_drop) |=> FRM_DROP_O && !FRM_FWD_O)
        else $error("storm excess broadcast forwarded");
    a_std_oversize: assert property
        ((FRM_END_I && !jumbo && !pass_all && FRM_LEN_I > 14'd1518) |=> FRM_DROP_O)
        else $error("oversize frame not dropped");
    a_bp_half_only: assert property
        (BACKPRESSURE_O |-> !$past(dup_q) && $past(bp_en))
        else $error("back pressure outside half duplex");
    a_pause_full: assert property
        (PAUSE_REQ_O |-> $past(dup_q)) else $error("pause in half duplex");
    a_bad_dropped: assert property
        ((FRM_END_I && FRM_CRC_ERR_I && !pass_all) |=> FRM_DROP_O && !FRM_FWD_O)
        else $error("crc error frame forwarded");
    a_fc_filter: assert property
        ((FRM_END_I && FRM_FC_I && FC_FRAME_FILTER_I) |=> FRM_DROP_O && !FRM_MIRROR_ONLY_O)
        else $error("filtered flow control frame passed");
    a_port_meter: assert property
        (port_based |-> meter_sel == 3'h0) else $error("port mode uses priority meter");
    a_rate_fc_gate: assert property
        ((PAUSE_REQ_O && !$past(CONGESTED_I)) |-> $past(rlfc_en) && $past(fc_permit))
        else $error("rate flow control not permitted");
    a_pkt_amount: assert property
        (pkt_mode |-> amount == 24'd1) else $error("packet mode amount not one");
    a_ifg_bytes: assert property
        ((!pkt_mode && ifg_en && !pre_en) |-> amount == 24'(FRM_LEN_I) + 24'd12)
        else $error("ifg bytes not added");
    a_lim_staged: assert property
        ((wr_en && hit_lim && lim_sel != 3'h7) |=> $stable(lim_act_q[0]))
        else $error("limit applied before priority 7 write");
    a_reset_zero: assert property
        ($rose(rst_n) |-> feat_q == 8'h00 && frame_q == 8'h00 && police_q == 8'h00)
        else $error("control bits not zero after reset");

endmodule // pmip_port_ctrl

/* File: verilog/pmip_rate_meter.sv */
`timescale 1ns/100ps
`include "pmip_defines.svh"

module pmip_rate_meter
(
    // clock and reset
    input  wire logic                  clk_i,
    input  wire logic                  rst_n_i,
    // window and events
    input  wire logic                  win_tick_i,
    input  wire logic                  hit_i,
    input  wire pmip_pkg::pmip_amount_t amount_i,
    input  wire pmip_pkg::pmip_amount_t limit_i,
    // status
    output logic                       over_o
);

    pmip_pkg::pmip_amount_t acc_q;
    pmip_pkg::pmip_amount_t acc_d;
    logic [24:0]            sum_w;
    logic                   over_q;

    // saturating accumulate, cleared each window
    assign sum_w = {1'b0, acc_q} + {1'b0, amount_i};
    assign acc_d = win_tick_i ? '0
                 : (hit_i ? (sum_w[24] ? '1 : sum_w[23:0]) : acc_q);
    assign over_o = over_q;

    always_ff @(posedge clk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
        begin
            acc_q  <= '0;
            over_q <= 1'b0;
        end
        else
        begin
            acc_q  <= acc_d;
            over_q <= (limit_i != '0) && (acc_d >= limit_i);
        end
    end

endmodule // pmip_rate_meter
